// [inc/rx_dma_pkg.sv]
// Package for the receive-channel transfer controller with timeout status.
// Assumes a single 100 MHz clock and an 8-bit register port.
package rx_dma_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] STATUS_OFFSET = 16'hffe5;
  localparam logic [15:0] CONTROL_OFFSET = 16'hffe4;
  localparam logic [15:0] BUFSTATE_OFFSET = 16'hffe6;

  // ---------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------
  localparam int OVERRUN_BIT = 0;
  localparam int TIMEOUT_STOP_BIT = 1;
  localparam int TIMEOUT_LSB = 2;
  localparam int TIMEOUT_MSB = 6;
  localparam int COUNT_ENABLE_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int IRQ_ENABLE_BIT = 6;
  localparam int CHANNEL_ENABLE_BIT = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Buffers and timing
  // ---------------------------------------------------------------
  localparam int PACKET_BYTES = 64;
  localparam int COUNT_WIDTH = 7;
  localparam int TIMEOUT_WIDTH = 5;

  typedef enum logic [1:0] {
    CAUSE_NONE,
    CAUSE_PARTIAL,
    CAUSE_OVERRUN,
    CAUSE_UART
  } stop_cause_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic valid;
    logic buf_sel;
    logic [COUNT_WIDTH-1:0] count;
  } buf_ready_type;

endpackage : rx_dma_pkg

// [core/rx_timeout_counter.sv]
// Transaction timeout down counter, ticked by start-of-frame strobes.
// Assumes sof and byte strobes are one-cycle pulses on clk.
`timescale 1ns/10ps
`default_nettype none
module rx_timeout_counter
  import rx_dma_pkg::*;
#(
  parameter int WIDTH = TIMEOUT_WIDTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic reload,
  input wire logic sof,
  input wire logic [WIDTH-1:0] load_value,
  output logic expired
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic armed_reg;
  logic armed_next;
  logic expired_next;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    count_next = count_reg;
    armed_next = armed_reg;
    expired_next = 1'b0;
    if (!run) begin
      armed_next = 1'b0;
    end else if (reload) begin
      count_next = load_value;
      armed_next = 1'b1;
    end else if (armed_reg && sof) begin
      if (count_reg <= WIDTH'(1)) begin
        count_next = '0;
        armed_next = 1'b0;
        expired_next = 1'b1;
      end else begin
        count_next = count_reg - WIDTH'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= '0;
      armed_reg <= 1'b0;
      expired <= 1'b0;
    end else begin
      count_reg <= count_next;
      armed_reg <= armed_next;
      expired <= expired_next;
    end
  end

endmodule : rx_timeout_counter
`default_nettype wire

// [core/rx_buffer_tracker.sv]
// Double-buffer fill tracker for the X and Y input buffers.
// Assumes the buffer manager pulses a release when it drains a buffer.
`timescale 1ns/10ps
`default_nettype none
module rx_buffer_tracker
  import rx_dma_pkg::*;
#(
  parameter int PACKET = PACKET_BYTES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clear,
  input wire logic write_byte,
  input wire logic flush,
  input wire logic release_x,
  input wire logic release_y,
  output logic can_write,
  output logic cur_sel,
  output logic [COUNT_WIDTH-1:0] fill,
  output logic [1:0] full,
  output buf_ready_type ready
);

  logic sel_next;
  logic [COUNT_WIDTH-1:0] fill_next;
  logic [1:0] full_next;
  buf_ready_type ready_next;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    sel_next = cur_sel;
    fill_next = fill;
    full_next = full;
    ready_next = '0;
    if (release_x) full_next[0] = 1'b0;
    if (release_y) full_next[1] = 1'b0;
    if (clear) begin
      fill_next = '0;
    end else if (write_byte && !full[cur_sel]) begin
      if (fill == COUNT_WIDTH'(PACKET - 1)) begin
        ready_next = '{1'b1, cur_sel, COUNT_WIDTH'(PACKET)};
        full_next[cur_sel] = 1'b1;
        fill_next = '0;
        sel_next = ~cur_sel;
      end else begin
        fill_next = fill + COUNT_WIDTH'(1);
      end
    end else if (flush && fill != '0) begin
      ready_next = '{1'b1, cur_sel, fill};
      full_next[cur_sel] = 1'b1;
      fill_next = '0;
      sel_next = ~cur_sel;
    end
  end

  assign can_write = !full[cur_sel];

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_sel <= 1'b0;
      fill <= '0;
      full <= 2'h0;
      ready <= '0;
    end else begin
      cur_sel <= sel_next;
      fill <= fill_next;
      full <= full_next;
      ready <= ready_next;
    end
  end

endmodule : rx_buffer_tracker
`default_nettype wire

// [core/rx_dma_channel.sv]
// Receive-channel transfer controller: timeout, completion code, enable.
// Assumes the UART, buffer manager and SOF strobe share clk.
`timescale 1ns/10ps
`default_nettype none
module rx_dma_channel
  import rx_dma_pkg::*;
#(
  parameter int PACKET = PACKET_BYTES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic uart_byte_valid,
  input wire logic uart_error,
  output logic uart_byte_taken,
  input wire logic sof,
  input wire logic release_x,
  input wire logic release_y,
  output buf_ready_type buf_ready,
  output logic [COUNT_WIDTH-1:0] fill_count,
  output logic buf_select,
  output logic irq
);

  reg_req_type req;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] control_reg;
  logic [7:0] control_next;
  logic halted_reg;
  logic halted_next;
  logic [7:0] rdata_next;
  logic irq_next;
  logic expired;
  logic can_write;
  logic cur_sel;
  logic [1:0] full;
  logic take;
  logic flush;
  logic run;
  logic enabled;
  stop_cause_type cause;

  assign req = '{addr, wdata, wr, rd};
  assign enabled = control_reg[CHANNEL_ENABLE_BIT];

  // ---------------------------------------------------------------
  // Byte intake and stop cause
  // ---------------------------------------------------------------
  assign take = enabled && !halted_reg && uart_byte_valid && can_write &&
    !uart_error;
  assign uart_byte_taken = take;
  assign run = status_reg[COUNT_ENABLE_BIT] && enabled && !halted_reg;

  always_comb begin
    cause = CAUSE_NONE;
    if (enabled && !halted_reg && uart_error) begin
      cause = CAUSE_UART;
    end else if (expired) begin
      if (full == 2'h3) begin
        cause = CAUSE_OVERRUN;
      end else begin
        cause = CAUSE_PARTIAL;
      end
    end
  end

  assign flush = (cause != CAUSE_NONE);

  rx_timeout_counter #(
    .WIDTH(TIMEOUT_WIDTH)
  ) u_timeout (
    .clk(clk),
    .arst_n(arst_n),
    .run(run),
    .reload(take),
    .sof(sof),
    .load_value(status_reg[TIMEOUT_MSB:TIMEOUT_LSB]),
    .expired(expired)
  );

  rx_buffer_tracker #(
    .PACKET(PACKET)
  ) u_buffers (
    .clk(clk),
    .arst_n(arst_n),
    .clear(!enabled),
    .write_byte(take),
    .flush(flush),
    .release_x(release_x),
    .release_y(release_y),
    .can_write(can_write),
    .cur_sel(cur_sel),
    .fill(fill_count),
    .full(full),
    .ready(buf_ready)
  );

  assign buf_select = cur_sel;

  // ---------------------------------------------------------------
  // Registers next state
  // ---------------------------------------------------------------
  always_comb begin
    status_next = status_reg;
    control_next = control_reg;
    halted_next = halted_reg;
    irq_next = 1'b0;
    if (req.wr && req.addr == STATUS_OFFSET) begin
      status_next[COUNT_ENABLE_BIT] = req.wdata[COUNT_ENABLE_BIT];
      status_next[TIMEOUT_MSB:TIMEOUT_LSB] =
        req.wdata[TIMEOUT_MSB:TIMEOUT_LSB];
      if (req.wdata[OVERRUN_BIT]) status_next[OVERRUN_BIT] = 1'b0;
      if (req.wdata[TIMEOUT_STOP_BIT]) begin
        status_next[TIMEOUT_STOP_BIT] = 1'b0;
      end
    end
    if (req.wr && req.addr == CONTROL_OFFSET) begin
      control_next = req.wdata;
      if (req.wdata[CHANNEL_ENABLE_BIT]) halted_next = 1'b0;
    end
    case (cause)
      CAUSE_PARTIAL: begin
        status_next[TIMEOUT_STOP_BIT] = 1'b1;
        status_next[OVERRUN_BIT] = 1'b0;
        halted_next = 1'b1;
      end
      CAUSE_OVERRUN: begin
        status_next[TIMEOUT_STOP_BIT] = 1'b1;
        status_next[OVERRUN_BIT] = 1'b1;
        halted_next = 1'b1;
      end
      CAUSE_UART: begin
        status_next[TIMEOUT_STOP_BIT] = 1'b1;
        status_next[OVERRUN_BIT] = 1'b0;
        halted_next = 1'b1;
      end
      default: begin
      end
    endcase
    if ((cause == CAUSE_PARTIAL || cause == CAUSE_OVERRUN) &&
        control_reg[IRQ_ENABLE_BIT]) begin
      control_next[CHANNEL_ENABLE_BIT] = 1'b0;
    end
    if (enabled && !control_next[CHANNEL_ENABLE_BIT] &&
        control_reg[IRQ_ENABLE_BIT]) begin
      irq_next = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    if (req.rd) begin
      case (req.addr)
        STATUS_OFFSET: rdata_next = status_reg;
        CONTROL_OFFSET: rdata_next = control_reg;
        BUFSTATE_OFFSET: rdata_next = {4'h0, halted_reg, cur_sel, full};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= STATUS_RESET;
      control_reg <= CONTROL_RESET;
      halted_reg <= 1'b0;
      rdata <= 8'h00;
      irq <= 1'b0;
    end else begin
      status_reg <= status_next;
      control_reg <= control_next;
      halted_reg <= halted_next;
      rdata <= rdata_next;
      irq <= irq_next;
    end
  end

endmodule : rx_dma_channel
`default_nettype wire

// [tb/rx_dma_channel_asserts.sv]
// Port checker for the receive-channel controller.
// Assumes it is bound onto rx_dma_channel, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module rx_dma_channel_asserts
  import rx_dma_pkg::*;
#(
  parameter int PACKET = PACKET_BYTES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic uart_byte_valid,
  input wire logic uart_byte_taken,
  input wire buf_ready_type buf_ready,
  input wire logic [COUNT_WIDTH-1:0] fill_count,
  input wire logic buf_select,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_rdata_idle; !$past(rd) |-> rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata busy");
  property p_irq_pulse; irq |=> !irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq long");
  property p_taken; uart_byte_taken |-> uart_byte_valid; endproperty
  a_taken: assert property (p_taken) else $error("taken no byte");
  property p_fill_max; fill_count <= PACKET; endproperty
  a_fill_max: assert property (p_fill_max) else $error("fill high");
  property p_fill_step;
    uart_byte_taken && fill_count < 7'h3f |=> fill_count == $past(fill_count) + 7'h01;
  endproperty
  a_fill_step: assert property (p_fill_step) else $error("fill step");
  property p_ready_cnt; buf_ready.valid |-> buf_ready.count inside {[1:PACKET]}; endproperty
  a_ready_cnt: assert property (p_ready_cnt) else $error("ready count");
  property p_ready_pulse; buf_ready.valid |=> !buf_ready.valid; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready long");
  property p_sel; $changed(buf_select) |-> buf_ready.valid || $past(buf_ready.valid); endproperty
  a_sel: assert property (p_sel) else $error("select moved");
endmodule : rx_dma_channel_asserts
bind rx_dma_channel rx_dma_channel_asserts #(.PACKET(PACKET)) asserts_i (
  .clk(clk), .arst_n(arst_n), .rd(rd), .rdata(rdata),
  .uart_byte_valid(uart_byte_valid), .uart_byte_taken(uart_byte_taken),
  .buf_ready(buf_ready), .fill_count(fill_count),
  .buf_select(buf_select), .irq(irq)
);
`default_nettype wire

// [tb/buf_mgr_model.sv]
// Buffer manager model: drains ready buffers, counts bytes sent.
// Assumes buf_ready pulses one cycle; stall holds buffers full.
`timescale 1ns/10ps
`default_nettype none
module buf_mgr_model
  import rx_dma_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic stall,
  input wire buf_ready_type buf_ready,
  output logic release_x,
  output logic release_y,
  output logic [7:0] sent
);
  logic [1:0] pend;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend <= 2'h0;
      release_x <= 1'b0;
      release_y <= 1'b0;
      sent <= 8'h00;
    end else begin
      release_x <= 1'b0;
      release_y <= 1'b0;
      if (buf_ready.valid) begin
        pend[buf_ready.buf_sel] <= 1'b1;
        sent <= sent + {1'b0, buf_ready.count};
      end else if (!stall && pend[0]) begin
        pend[0] <= 1'b0;
        release_x <= 1'b1;
      end else if (!stall && pend[1]) begin
        pend[1] <= 1'b0;
        release_y <= 1'b1;
      end
    end
  end
endmodule : buf_mgr_model
`default_nettype wire

// [tb/testbench.sv]
// Register-level tests of the receive-channel controller.
// Assumes the buffer manager model and the port checker.
`timescale 1ns/10ps
`default_nettype none
module testbench import rx_dma_pkg::*;;
  logic clk, arst_n, wr, rd, uart_byte_valid, uart_error, sof, stall;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, sent, irqs;
  logic uart_byte_taken, release_x, release_y, buf_select, irq;
  buf_ready_type buf_ready;
  logic [COUNT_WIDTH-1:0] fill_count;
  int err_count, total_checks;
  rx_dma_channel rx_dma_channel_i (.clk(clk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .uart_byte_valid(uart_byte_valid), .uart_error(uart_error),
    .uart_byte_taken(uart_byte_taken), .sof(sof), .release_x(release_x),
    .release_y(release_y), .buf_ready(buf_ready), .fill_count(fill_count),
    .buf_select(buf_select), .irq(irq));
  buf_mgr_model buf_mgr_model_i (.clk(clk), .arst_n(arst_n), .stall(stall),
    .buf_ready(buf_ready), .release_x(release_x), .release_y(release_y),
    .sent(sent));
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) irqs <= 8'h00;
    else if (irq === 1'b1) irqs <= irqs + 8'h01;
  end
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk) addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 check("register", rdata, exp);
  endtask : rd_reg
  task send(input int n);
    int k, t;
    k = 0;
    t = 0;
    uart_byte_valid <= 1'b1;
    while (k < n && t < 2000) begin
      @(posedge clk) t++;
      if (uart_byte_taken === 1'b1) k++;
    end
    uart_byte_valid <= 1'b0;
    check("bytes", k[7:0], n[7:0]);
  endtask : send
  task sofs(input int n);
    repeat (n) begin
      @(posedge clk) sof <= 1'b1;
      @(posedge clk) sof <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask : sofs
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #300000 err_count++;
    give_verdict;
  end
  initial begin
    {arst_n, wr, rd, uart_byte_valid, uart_error, sof, stall} = 7'h00;
    addr = 16'h0000;
    wdata = 8'h00;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd_reg(STATUS_OFFSET, 8'h00);
    rd_reg(16'hff00, 8'h00);
    wr_reg(STATUS_OFFSET, 8'hff);
    rd_reg(STATUS_OFFSET, 8'hfc);
    $display("test fields done");
    wr_reg(STATUS_OFFSET, 8'h88);
    wr_reg(CONTROL_OFFSET, 8'h80);
    send(64);
    repeat (4) @(posedge clk);
    check("sent", sent, 8'h40);
    check("select", {7'h00, buf_select}, 8'h01);
    $display("test block done");
    send(5);
    sofs(3);
    rd_reg(STATUS_OFFSET, 8'h8a);
    rd_reg(CONTROL_OFFSET, 8'h80);
    check("irq", irqs, 8'h00);
    check("sent", sent, 8'h45);
    wr_reg(STATUS_OFFSET, 8'h88);
    rd_reg(STATUS_OFFSET, 8'h8a);
    wr_reg(STATUS_OFFSET, 8'h8a);
    rd_reg(STATUS_OFFSET, 8'h88);
    $display("test partial done");
    wr_reg(CONTROL_OFFSET, 8'hc0);
    send(1);
    sofs(3);
    check("irq", irqs, 8'h01);
    rd_reg(CONTROL_OFFSET, 8'h40);
    wr_reg(STATUS_OFFSET, 8'h8a);
    $display("test irq done");
    stall <= 1'b1;
    wr_reg(CONTROL_OFFSET, 8'hc0);
    send(128);
    sofs(3);
    rd_reg(STATUS_OFFSET, 8'h8b);
    check("irq", irqs, 8'h02);
    stall <= 1'b0;
    wr_reg(STATUS_OFFSET, 8'h8b);
    rd_reg(STATUS_OFFSET, 8'h88);
    $display("test overrun done");
    wr_reg(STATUS_OFFSET, 8'h08);
    wr_reg(CONTROL_OFFSET, 8'h80);
    send(1);
    sofs(4);
    rd_reg(STATUS_OFFSET, 8'h08);
    rd_reg(CONTROL_OFFSET, 8'h80);
    $display("test disabled done");
    @(posedge clk) uart_error <= 1'b1;
    @(posedge clk) uart_error <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(CONTROL_OFFSET, 8'h80);
    rd_reg(STATUS_OFFSET, 8'h0a);
    check("irq", irqs, 8'h02);
    $display("test uart error done");
    wr_reg(CONTROL_OFFSET, 8'hc0);
    wr_reg(CONTROL_OFFSET, 8'h40);
    rd_reg(CONTROL_OFFSET, 8'h40);
    check("irq", irqs, 8'h03);
    $display("test software stop done");
    give_verdict;
  end
endmodule : testbench
`default_nettype wire
